// *** legacy_timer_pkg.sv ***
// Constants for the legacy compatibility timer and PWM block
package legacy_timer_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_GENERAL = 8'h04;
    localparam logic [7:0] OFF_COMPARE_A = 8'h08;
    localparam logic [7:0] OFF_TOP = 8'h0C;
    localparam logic [7:0] OFF_COUNTER = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_GLOBAL = 8'h1C;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTC_BIT = 7;
    localparam int PWM_A_BIT = 6;
    localparam int COM_HI_BIT = 5;
    localparam int COM_LO_BIT = 4;
    localparam int CS_HI_BIT = 3;
    localparam int FORCE_BIT = 2;
    localparam int PSR_BIT = 1;
    localparam int COMPARE_FLAG_BIT = 6;
    localparam int OVERFLOW_FLAG_BIT = 2;
    localparam int GIE_BIT = 0;
    localparam int COMPAT_BIT = 1;
    localparam logic [7:0] MASK_BITS = 8'h44;
    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] FUSE_COMPAT = 4'h3;
    localparam logic [3:0] CS_STOP = 4'h0;
    localparam logic [3:0] CS_FAST_1 = 4'h1;
    localparam logic [3:0] CS_FAST_2 = 4'h2;
    localparam logic [3:0] CS_FAST_4 = 4'h3;
    localparam logic [3:0] CS_FAST_8 = 4'h4;
    localparam logic [3:0] CS_CORE_1 = 4'h5;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CORE_DIV_W = 10;
    localparam int FAST_DIV_W = 3;
endpackage : legacy_timer_pkg

// *** legacy_compat_timer_pwm.sv ***
// Legacy compatibility 8-bit timer with prescaler and PWM, AXI4-Lite regs
// Behaviour
// - Compat mode only when fuses equal 0011
// - Ten-bit core and three-bit fast dividers
// - Timer clocking always synchronous in compat
// - Mux offers stop, fast/1..8, core/1..1024
// - Written values pass a sync stage first, except mask and global enable
// - Control and compare registers read back immediately
// - Counter and flag reads lag through sync
// - Only compare A acts; drives pin, flag
// - Normal mode overflow on wrap to zero
// - PWM counts zero to top, then restarts
// - PWM overflow on top match or wrap
// - PWM output modes: off, off unless compare A is zero or top, clear, set
// - PWM compare A buffered until top reached
// - Compare A read returns latest written value
// - Compare A zero or top holds pin static
// - Interrupt request needs flag, enable, global enable
// - PWM period is top plus one ticks
// - Active time is compare plus one ticks
// - Codes one to three pick fast/1,2,4
// - PWM enable bit selects PWM mode
// - Clock select zero stops the timer
// - Flags clear by ack or write-one, delayed
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module legacy_compat_timer_pwm #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] clock_source_fuses,
    input wire logic core_clock_tick,
    input wire logic fast_peripheral_clock_tick,
    input wire logic overflow_ack,
    input wire logic compare_ack,
    output logic overflow_irq,
    output logic compare_irq,
    output logic pwm_output_pin,
    output logic pwm_output_enable,
    output logic compat_active
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] fuse_s1;
        logic [3:0] fuse_s2;
        logic compat;
        logic [7:0] timer_control_reg;
        logic [7:0] control_sync;
        logic [7:0] compare_hold;
        logic [7:0] compare_a_value;
        logic [7:0] top_value;
        logic [7:0] top_sync;
        logic [7:0] timer_mask_reg;
        logic gie;
        logic [7:0] counter_value;
        logic counter_write_pend;
        logic [7:0] counter_write_val;
        logic [legacy_timer_pkg::CORE_DIV_W-1:0] core_div;
        logic [legacy_timer_pkg::FAST_DIV_W-1:0] fast_div;
        logic psr_pend;
        logic force_pend;
        logic compare_a_flag;
        logic overflow_flag;
        logic compare_clr_pend;
        logic overflow_clr_pend;
        logic [7:0] counter_read;
        logic compare_read;
        logic overflow_read;
        logic pin;
        logic pin_oe;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } state_type;

    state_type r;
    state_type next_r;
    logic tick;
    logic pwm;
    logic [1:0] com;
    logic [3:0] cs;
    logic top_hit;
    logic overflow_event;
    logic compare_event;
    logic static_pin;
    logic [7:0] count_next;
    logic [legacy_timer_pkg::CORE_DIV_W-1:0] core_mask;
    logic [3:0] core_shift;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        pwm = r.control_sync[legacy_timer_pkg::PWM_A_BIT];
        com = r.control_sync[legacy_timer_pkg::COM_HI_BIT:
                             legacy_timer_pkg::COM_LO_BIT];
        cs = r.control_sync[legacy_timer_pkg::CS_HI_BIT:0];
        // Fuse pins pass two flops before decode
        next_r.fuse_s1 = clock_source_fuses;
        next_r.fuse_s2 = r.fuse_s1;
        next_r.compat = (r.fuse_s2 == legacy_timer_pkg::FUSE_COMPAT);
        next_r.control_sync = r.timer_control_reg;
        next_r.top_sync = r.top_value;
        next_r.counter_read = r.counter_value;
        next_r.compare_read = r.compare_a_flag;
        next_r.overflow_read = r.overflow_flag;

        next_r.core_div = r.core_div + {{(legacy_timer_pkg::CORE_DIV_W-1){
            1'b0}}, core_clock_tick};
        next_r.fast_div = r.fast_div + {{(legacy_timer_pkg::FAST_DIV_W-1){
            1'b0}}, fast_peripheral_clock_tick};
        if (r.psr_pend) begin
            next_r.core_div = '0;
            next_r.fast_div = '0;
        end
        next_r.psr_pend = 1'b0;

        core_shift = cs - legacy_timer_pkg::CS_CORE_1;
        for (int i = 0; i < legacy_timer_pkg::CORE_DIV_W; i++) begin
            core_mask[i] = (i < int'(core_shift));
        end
        // ticks share the core clock, no resync
        unique case (cs)
            legacy_timer_pkg::CS_STOP: tick = 1'b0;
            legacy_timer_pkg::CS_FAST_1: tick = fast_peripheral_clock_tick;
            legacy_timer_pkg::CS_FAST_2:
                tick = fast_peripheral_clock_tick & r.fast_div[0];
            legacy_timer_pkg::CS_FAST_4:
                tick = fast_peripheral_clock_tick & (&r.fast_div[1:0]);
            legacy_timer_pkg::CS_FAST_8:
                tick = fast_peripheral_clock_tick & (&r.fast_div);
            default:
                tick = core_clock_tick & (&(r.core_div | ~core_mask));
        endcase
        // timer runs only in compat mode
        tick = tick & r.compat;

        // count up; PWM restarts after top, CTC after compare A
        top_hit = (r.counter_value == r.top_sync);
        count_next = r.counter_value + 8'h01;
        // PWM counter clears after top match
        if (pwm && top_hit) begin
            count_next = 8'h00;
        end else if (!pwm && r.control_sync[legacy_timer_pkg::CTC_BIT]
                     && r.counter_value == r.compare_a_value) begin
            count_next = 8'h00;
        end
        overflow_event = tick && !r.counter_write_pend &&
            (r.counter_value == legacy_timer_pkg::COUNT_MAX ||
             (pwm && top_hit));
        compare_event = tick && !r.counter_write_pend &&
            (r.counter_value == r.compare_a_value);
        if (r.counter_write_pend) begin
            next_r.counter_value = r.counter_write_val;
        end else if (tick) begin
            next_r.counter_value = count_next;
        end
        next_r.counter_write_pend = 1'b0;

        if (!pwm) begin
            next_r.compare_a_value = r.compare_hold;
        end else if (tick && top_hit) begin
            next_r.compare_a_value = r.compare_hold;
        end

        // flag set wins over delayed clear
        next_r.compare_a_flag = (r.compare_a_flag &
            !(r.compare_clr_pend | compare_ack)) | compare_event;
        next_r.overflow_flag = (r.overflow_flag &
            !(r.overflow_clr_pend | overflow_ack)) | overflow_event;
        next_r.compare_clr_pend = 1'b0;
        next_r.overflow_clr_pend = 1'b0;

        // static output at zero or top
        static_pin = (r.compare_a_value == 8'h00) ||
            (r.compare_a_value == r.top_sync);
        if (pwm) begin
            next_r.pin_oe = com[1] ||
                (com == legacy_timer_pkg::COM_TOGGLE && static_pin);
            if (static_pin) begin
                next_r.pin = (r.compare_a_value == 8'h00) ?
                    (com == legacy_timer_pkg::COM_SET) :
                    (com != legacy_timer_pkg::COM_SET);
            // compare level held until counter wraps to zero
            end else if (com[1] && compare_event) begin
                next_r.pin = com[0];
            end else if (com[1] && tick && count_next == 8'h00) begin
                next_r.pin = ~com[0];
            end
        end else begin
            next_r.pin_oe = (com != legacy_timer_pkg::COM_OFF);
            if (compare_event || r.force_pend) begin
                unique case (com)
                    legacy_timer_pkg::COM_OFF: next_r.pin = r.pin;
                    legacy_timer_pkg::COM_TOGGLE: next_r.pin = ~r.pin;
                    legacy_timer_pkg::COM_CLEAR: next_r.pin = 1'b0;
                    legacy_timer_pkg::COM_SET: next_r.pin = 1'b1;
                endcase
            end
        end
        next_r.force_pend = 1'b0;

        // --------------------------------------------------------------
        // AXI4-Lite write channels, address and data in either order
        // --------------------------------------------------------------
        if (s_axi_awvalid && s_axi_awready) begin
            next_r.aw_got = 1'b1;
            next_r.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_r.w_got = 1'b1;
            next_r.w_data = s_axi_wdata[7:0];
            next_r.w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = legacy_timer_pkg::RESP_OKAY;
            unique case (r.aw_addr)
                legacy_timer_pkg::OFF_CONTROL:
                    if (r.w_lane0) next_r.timer_control_reg = r.w_data;
                legacy_timer_pkg::OFF_GENERAL:
                    if (r.w_lane0) begin
                        next_r.force_pend =
                            r.w_data[legacy_timer_pkg::FORCE_BIT];
                        next_r.psr_pend = r.w_data[legacy_timer_pkg::PSR_BIT];
                    end
                legacy_timer_pkg::OFF_COMPARE_A:
                    if (r.w_lane0) next_r.compare_hold = r.w_data;
                legacy_timer_pkg::OFF_TOP:
                    if (r.w_lane0) next_r.top_value = r.w_data;
                // counter write applied one cycle later
                legacy_timer_pkg::OFF_COUNTER:
                    if (r.w_lane0) begin
                        next_r.counter_write_pend = 1'b1;
                        next_r.counter_write_val = r.w_data;
                    end
                legacy_timer_pkg::OFF_FLAGS:
                    if (r.w_lane0) begin
                        next_r.compare_clr_pend =
                            r.w_data[legacy_timer_pkg::COMPARE_FLAG_BIT];
                        next_r.overflow_clr_pend =
                            r.w_data[legacy_timer_pkg::OVERFLOW_FLAG_BIT];
                    end
                legacy_timer_pkg::OFF_MASK:
                    if (r.w_lane0) next_r.timer_mask_reg =
                        r.w_data & legacy_timer_pkg::MASK_BITS;
                legacy_timer_pkg::OFF_GLOBAL:
                    if (r.w_lane0) next_r.gie =
                        r.w_data[legacy_timer_pkg::GIE_BIT];
                default: next_r.bresp = legacy_timer_pkg::RESP_SLVERR;
            endcase
        end

        // --------------------------------------------------------------
        // AXI4-Lite read channel
        // --------------------------------------------------------------
        if (s_axi_rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = legacy_timer_pkg::RESP_OKAY;
            next_r.rdata = legacy_timer_pkg::REG_RESET;
            unique case (s_axi_araddr[7:0])
                legacy_timer_pkg::OFF_CONTROL:
                    next_r.rdata = r.timer_control_reg;
                legacy_timer_pkg::OFF_GENERAL:
                    next_r.rdata = legacy_timer_pkg::REG_RESET;
                legacy_timer_pkg::OFF_COMPARE_A:
                    next_r.rdata = r.compare_hold;
                legacy_timer_pkg::OFF_TOP: next_r.rdata = r.top_value;
                legacy_timer_pkg::OFF_COUNTER: next_r.rdata = r.counter_read;
                legacy_timer_pkg::OFF_FLAGS: begin
                    next_r.rdata[legacy_timer_pkg::COMPARE_FLAG_BIT] =
                        r.compare_read;
                    next_r.rdata[legacy_timer_pkg::OVERFLOW_FLAG_BIT] =
                        r.overflow_read;
                end
                legacy_timer_pkg::OFF_MASK: next_r.rdata = r.timer_mask_reg;
                legacy_timer_pkg::OFF_GLOBAL: begin
                    next_r.rdata[legacy_timer_pkg::GIE_BIT] = r.gie;
                    next_r.rdata[legacy_timer_pkg::COMPAT_BIT] = r.compat;
                end
                default: next_r.rresp = legacy_timer_pkg::RESP_SLVERR;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = !r.aw_got && !r.bvalid;
    assign s_axi_wready = !r.w_got && !r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = {24'h00_0000, r.rdata};
    assign overflow_irq = r.overflow_flag && r.gie &&
        r.timer_mask_reg[legacy_timer_pkg::OVERFLOW_FLAG_BIT];
    assign compare_irq = r.compare_a_flag && r.gie &&
        r.timer_mask_reg[legacy_timer_pkg::COMPARE_FLAG_BIT];
    assign pwm_output_pin = r.pin;
    assign pwm_output_enable = r.pin_oe;
    assign compat_active = r.compat;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    compat_gate_a: assert property (!r.compat |-> !tick)
        else $error("timer ticked outside compat mode");
    fast_div_a: assert property (
        (cs == legacy_timer_pkg::CS_FAST_4 && tick) |->
        r.fast_div[1:0] == 2'h3 && fast_peripheral_clock_tick)
        else $error("fast divide by four ticked early");
    stop_hold_a: assert property (
        (cs == legacy_timer_pkg::CS_STOP && !r.counter_write_pend) |=>
        r.counter_value == $past(r.counter_value))
        else $error("counter moved while stopped");
    sync_stage_a: assert property (
        (r.timer_control_reg != r.control_sync) |=>
        r.control_sync == $past(r.timer_control_reg))
        else $error("control did not pass sync stage");
    pwm_wrap_a: assert property (
        (pwm && tick && top_hit && !r.counter_write_pend) |=>
        r.counter_value == 8'h00 && r.overflow_flag)
        else $error("PWM counter did not restart at top");
    flag_clear_a: assert property (
        (r.overflow_clr_pend && !overflow_event) |=> !r.overflow_flag)
        else $error("overflow flag not cleared");
    buffer_hold_a: assert property (
        (pwm && !(tick && top_hit)) |=> $stable(r.compare_a_value))
        else $error("compare A changed before top");
    read_lag_a: assert property (
        ##2 r.counter_read == $past(r.counter_value, 2) ||
        $past(r.counter_value, 2) != $past(r.counter_value, 1) ||
        r.counter_read == $past(r.counter_value))
        else $error("counter read view not delayed");
    irq_path_a: assert property (
        (compare_event && r.gie &&
         r.timer_mask_reg[legacy_timer_pkg::COMPARE_FLAG_BIT]) ##1
        $stable(r.gie) |-> compare_irq)
        else $error("compare interrupt not requested");
    static_pin_a: assert property (
        (pwm && r.compare_a_value == 8'h00 &&
         com == legacy_timer_pkg::COM_SET) |=> r.pin)
        else $error("static pin wrong for mode set");
endmodule : legacy_compat_timer_pwm

// *** legacy_compat_timer_pwm_bench.sv ***
// Self-checking bench for the legacy compatibility timer and PWM block
`timescale 1ns/1ps
module legacy_compat_timer_pwm_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] fuses = 4'h3;
    logic ctick = 1'b0, ftick = 1'b0, oack = 1'b0, cack = 1'b0;
    logic oirq, cirq, pin, pin_en, compat;
    logic [33:0] expq[$];
    int n_mismatch = 0, cmp_count = 0, seed = 32'h22f2, hi, lo;
    logic [7:0] cval, top, com;

    initial begin
        forever #2 aclk = ~aclk;
    end

    legacy_compat_timer_pwm DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .clock_source_fuses(fuses),
        .core_clock_tick(ctick), .fast_peripheral_clock_tick(ftick),
        .overflow_ack(oack), .compare_ack(cack), .overflow_irq(oirq),
        .compare_irq(cirq), .pwm_output_pin(pin),
        .pwm_output_enable(pin_en), .compat_active(compat));

    task check(input logic [33:0] seen, input logic [33:0] exp, string nm);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : check

    task close_out;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        check({32'h0000_0000, bresp}, {32'h0000_0000, r}, "bresp");
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        expq.push_back({r, 24'h00_0000, d});
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
    endtask : rd

    // Pin high and low spans over one full period
    task measure;
        hi = 0;
        lo = 0;
        while (pin !== 1'b0) @(posedge aclk);
        while (pin !== 1'b1) @(posedge aclk);
        while (pin === 1'b1) begin @(posedge aclk); hi++; end
        while (pin === 1'b0) begin @(posedge aclk); lo++; end
    endtask : measure

    always @(posedge aclk) begin
        if (rvalid && rready) begin
            check({rresp, rdata}, expq.pop_front(), "read data");
        end
    end

    initial begin
        #(4 * 20000);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4), 8'h00, 2'h0);
        end
        rd(legacy_timer_pkg::OFF_GLOBAL, 8'h02, 2'h0);
        rd(8'h20, 8'h00, legacy_timer_pkg::RESP_SLVERR);
        $display("reset and map test done");
        cval = 8'($random(seed));
        wr(legacy_timer_pkg::OFF_COMPARE_A, 8'h80, 2'h0);
        rd(legacy_timer_pkg::OFF_COMPARE_A, 8'h80, 2'h0);
        wr(legacy_timer_pkg::OFF_COUNTER, cval, 2'h0);
        repeat (4) @(posedge aclk);
        rd(legacy_timer_pkg::OFF_COUNTER, cval, 2'h0);
        wr(legacy_timer_pkg::OFF_COUNTER, 8'hFD, 2'h0);
        ctick <= 1'b1;
        wr(legacy_timer_pkg::OFF_CONTROL, 8'h05, 2'h0);
        repeat (8) @(posedge aclk);
        wr(legacy_timer_pkg::OFF_CONTROL, 8'h00, 2'h0);
        repeat (3) @(posedge aclk);
        rd(legacy_timer_pkg::OFF_FLAGS, 8'h04, 2'h0);
        wr(legacy_timer_pkg::OFF_FLAGS, 8'h04, 2'h0);
        repeat (3) @(posedge aclk);
        rd(legacy_timer_pkg::OFF_FLAGS, 8'h00, 2'h0);
        $display("normal mode test done");
        top = 8'h09;
        ftick <= 1'b1;
        wr(legacy_timer_pkg::OFF_TOP, top, 2'h0);
        // Counter back inside the period so compare A latches at top
        wr(legacy_timer_pkg::OFF_COUNTER, 8'h00, 2'h0);
        for (int m = 0; m < 4; m++) begin
            com = 8'(m);
            cval = 8'($unsigned($random(seed)) % 8 + 1);
            wr(legacy_timer_pkg::OFF_COMPARE_A, cval, 2'h0);
            rd(legacy_timer_pkg::OFF_COMPARE_A, cval, 2'h0);
            wr(legacy_timer_pkg::OFF_CONTROL, 8'h41 | (com << 4), 2'h0);
            repeat (30) @(posedge aclk);
            check(34'(pin_en), 34'(com[1]), "pin enable");
            if (com[1]) begin
                measure();
                check(34'(hi + lo), 34'(top) + 1, "period");
                check(34'(com[0] ? lo : hi), 34'(cval) + 1, "active");
            end
        end
        wr(legacy_timer_pkg::OFF_CONTROL, 8'h62, 2'h0);
        repeat (40) @(posedge aclk);
        measure();
        check(34'(hi + lo), 2 * (34'(top) + 1), "half rate period");
        for (int m = 2; m < 4; m++) begin
            wr(legacy_timer_pkg::OFF_COMPARE_A, 8'h00, 2'h0);
            wr(legacy_timer_pkg::OFF_CONTROL, 8'h41 | 8'(m << 4), 2'h0);
            repeat (30) @(posedge aclk);
            hi = 0;
            repeat (20) begin @(posedge aclk); hi += int'(pin === 1'b1); end
            check(34'(hi), (m == 3) ? 34'd20 : 34'd0, "static pin");
        end
        $display("pwm test done");
        wr(legacy_timer_pkg::OFF_MASK, 8'h44, 2'h0);
        wr(legacy_timer_pkg::OFF_GLOBAL, 8'h01, 2'h0);
        wr(legacy_timer_pkg::OFF_CONTROL, 8'h00, 2'h0);
        repeat (3) @(posedge aclk);
        check(34'({oirq, cirq}), 34'h0_0000_0003, "irq pair");
        oack <= 1'b1;
        @(posedge aclk);
        oack <= 1'b0;
        repeat (3) @(posedge aclk);
        check(34'({oirq, cirq}), 34'h0_0000_0001, "irq after ack");
        cack <= 1'b1;
        @(posedge aclk);
        cack <= 1'b0;
        repeat (3) @(posedge aclk);
        check(34'({oirq, cirq}), 34'h0_0000_0000, "irq after cack");
        fuses <= 4'h0;
        repeat (5) @(posedge aclk);
        check(34'(compat), 34'h0_0000_0000, "compat flag");
        $display("interrupt and fuse test done");
        close_out();
    end
endmodule : legacy_compat_timer_pwm_bench
